// ---- src/t2_byte_counter.v ----
// Purpose: One 8-bit count byte with tick, reload and software load
// Assumes: All inputs on the system clock
// Notes: Overflow pulse marks a step taken while the count is 0xff
`timescale 1ns/100ps
module t2_byte_counter (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_step,
  input wire i_reload,
  input wire [7:0] i_reload_value,
  input wire i_load,
  input wire [7:0] i_load_value,
  output reg [7:0] o_count,
  output wire o_wrap
);
  assign o_wrap = i_step && (o_count == 8'hff);

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= 8'h00;
    end else if (i_load) begin
      o_count <= i_load_value;
    end else if (i_reload) begin
      o_count <= i_reload_value;
    end else if (i_step) begin
      o_count <= o_count + 8'h01;
    end
  end
endmodule // t2_byte_counter

// ---- src/t2_rate_divider.v ----
// Purpose: Turns a stream of ticks into one pulse every DIV ticks
// Assumes: One clock domain; i_tick counts once in every cycle it is high (held high for divide-by-12)
// Notes: Used for the divide-by-12 and divide-by-8 prescalers
`timescale 1ns/100ps
module t2_rate_divider #(
  parameter DIV = 12,
  parameter W = 4
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_tick,
  output reg o_pulse
);
  reg [W-1:0] count;

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= {W{1'b0}};
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= 1'b0;
      if (i_tick) begin
        if (count == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
          count <= {W{1'b0}};
          o_pulse <= 1'b1;
        end else begin
          count <= count + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // t2_rate_divider

// ---- src/timer2_consts.vh ----
// Purpose: Register offsets, field positions, reset values and counts for the reload timer
// Assumes: Register offsets are byte indices; the bus byte address is four times the index
// Notes: Definitions only
`ifndef TIMER2_CONSTS_VH
`define TIMER2_CONSTS_VH

`define T2_IDX_CONTROL 8'hc8
`define T2_IDX_RELOAD_LOW 8'hca
`define T2_IDX_RELOAD_HIGH 8'hcb
`define T2_IDX_COUNT_LOW 8'hcc
`define T2_IDX_COUNT_HIGH 8'hcd
`define T2_IDX_CLOCK_CONTROL 8'hc0
`define T2_IDX_IRQ_STATUS 8'hc1
`define T2_IDX_IRQ_MASK 8'hc2

`define T2_BIT_HIGH_FLAG 7
`define T2_BIT_LOW_FLAG 6
`define T2_BIT_LOW_IRQ_EN 5
`define T2_BIT_CAPTURE_EN 4
`define T2_BIT_SPLIT 3
`define T2_BIT_RUN 2
`define T2_BIT_UNUSED 1
`define T2_BIT_EXT_CLK 0

`define T2_BIT_CLK_LOW_SYS 0
`define T2_BIT_CLK_HIGH_SYS 1
`define T2_BIT_TIMER_IRQ_EN 2

`define T2_EV_HIGH_OVF 0
`define T2_EV_LOW_OVF 1
`define T2_EV_CAPTURE 2

`define T2_CONTROL_RESET 8'h00
`define T2_RELOAD_RESET 8'h00
`define T2_CLOCK_CONTROL_RESET 8'h00
`define T2_IRQ_MASK_RESET 8'h00

`define T2_SYS_DIV 12
`define T2_EXT_DIV 8
`define T2_CAPTURE_LATENCY 1

`endif

// ---- src/timer2_control_reload.v ----
// Purpose: Control, status and reload logic of a 16-bit or split 8-bit auto-reload timer
// Assumes: Avalon-MM slave, byte address = 4 x register index, data in low byte
// Notes: Comparator and external clock are pins, synchronised before use
// Function
// - Set high flag on high byte wrap
// - High flag raises enabled timer interrupt
// - Set low flag on every low wrap
// - Only software clears overflow flags
// - Low overflow interrupts when low enable set
// - Comparator rising edge captures count into reload
// - Capture raises enabled timer interrupt
// - Split bit picks 16-bit or dual 8-bit
// - Run gates counting; split low always runs
// - Control bit 1 reads zero, ignores writes
// - External select picks div12 or ext div8
// - External select applies to both bytes
// - Control resets zero, single bits writable
// - Reload low byte read/write, resets zero
// - 16-bit wrap loads reload pair
// - Split bytes reload from own reload byte
// - Byte clock select picks system clock
// - Reload high byte read/write, resets zero
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/100ps
`include "timer2_consts.vh"
module timer2_control_reload (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [9:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  input wire [3:0] i_byteenable,
  input wire i_comparator,
  input wire i_ext_clk,
  output reg [31:0] o_readdata,
  output reg o_waitrequest,
  output reg [1:0] o_response,
  output reg o_timer_irq,
  output reg o_irq
);
  reg [7:0] control;
  reg [7:0] reload_low;
  reg [7:0] reload_high;
  reg [7:0] clock_control;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  reg cmp_meta, cmp_sync, cmp_prev;
  reg ext_meta, ext_sync, ext_prev;
  reg done;
  wire [7:0] count_low;
  wire [7:0] count_high;
  wire low_wrap, high_wrap;
  wire div12_pulse, ext8_pulse;
  wire ext_edge = ext_sync && !ext_prev;
  wire cmp_edge = cmp_sync && !cmp_prev;
  wire split = control[`T2_BIT_SPLIT];
  wire run = control[`T2_BIT_RUN];
  wire access = (i_read || i_write) && o_waitrequest && !done;
  // Write lands on the edge where the master sees waitrequest low
  wire wr_ok = i_write && !o_waitrequest && i_byteenable[0];
  wire [7:0] idx = i_address[9:2];
  wire [7:0] wdata = i_writedata[7:0];

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Pin synchronisers; first stage feeds only the second
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      cmp_prev <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      cmp_meta <= i_comparator;
      cmp_sync <= cmp_meta;
      cmp_prev <= cmp_sync;
      ext_meta <= i_ext_clk;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  t2_rate_divider #(.DIV(`T2_SYS_DIV), .W(4)) u_div12 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_tick(1'b1),
    .o_pulse(div12_pulse)
  );

  t2_rate_divider #(.DIV(`T2_EXT_DIV), .W(4)) u_div8 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_tick(ext_edge),
    .o_pulse(ext8_pulse)
  );

  // Shared slow source, then per-byte override
  wire slow_tick = control[`T2_BIT_EXT_CLK] ? ext8_pulse : div12_pulse;
  wire low_tick = clock_control[`T2_BIT_CLK_LOW_SYS] ? 1'b1 : slow_tick;
  wire high_tick = clock_control[`T2_BIT_CLK_HIGH_SYS] ? 1'b1 : slow_tick;

  // In 16-bit mode the low byte clock drives the pair; high steps on low carry
  wire low_step = split ? low_tick : (run && low_tick);
  wire high_step = split ? (run && high_tick) : low_wrap;
  wire wrap16 = !split && high_wrap;
  wire low_reload = split ? low_wrap : wrap16;
  wire high_reload = high_wrap;
  wire sw_low = wr_ok && hit(idx, `T2_IDX_COUNT_LOW);
  wire sw_high = wr_ok && hit(idx, `T2_IDX_COUNT_HIGH);

  t2_byte_counter u_low (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_step(low_step),
    .i_reload(low_reload),
    .i_reload_value(reload_low),
    .i_load(sw_low),
    .i_load_value(wdata),
    .o_count(count_low),
    .o_wrap(low_wrap)
  );

  t2_byte_counter u_high (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_step(high_step),
    .i_reload(high_reload),
    .i_reload_value(reload_high),
    .i_load(sw_high),
    .i_load_value(wdata),
    .o_count(count_high),
    .o_wrap(high_wrap)
  );

  // Capture only meaningful in 16-bit mode
  wire capture = control[`T2_BIT_CAPTURE_EN] && !split && cmp_edge;

  wire [7:0] control_wval = {wdata[7:2], 1'b0, wdata[0]};
  wire ctl_wr = wr_ok && hit(idx, `T2_IDX_CONTROL);
  wire rd_status = i_read && access && hit(idx, `T2_IDX_IRQ_STATUS);

  // Control; hardware sets beat software clears in the same cycle
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control <= `T2_CONTROL_RESET;
    end else begin
      if (ctl_wr) begin
        control <= control_wval;
      end
      if (high_wrap || capture) begin
        control[`T2_BIT_HIGH_FLAG] <= 1'b1;
      end
      if (low_wrap) begin
        control[`T2_BIT_LOW_FLAG] <= 1'b1;
      end
    end
  end

  // Capture wins over software write of the same reload byte
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reload_low <= `T2_RELOAD_RESET;
      reload_high <= `T2_RELOAD_RESET;
    end else if (capture) begin
      reload_low <= count_low;
      reload_high <= count_high;
    end else begin
      if (wr_ok && hit(idx, `T2_IDX_RELOAD_LOW)) begin
        reload_low <= wdata;
      end
      if (wr_ok && hit(idx, `T2_IDX_RELOAD_HIGH)) begin
        reload_high <= wdata;
      end
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clock_control <= `T2_CLOCK_CONTROL_RESET;
      irq_mask <= 3'h0;
    end else begin
      if (wr_ok && hit(idx, `T2_IDX_CLOCK_CONTROL)) begin
        clock_control <= {5'h00, wdata[2:0]};
      end
      if (wr_ok && hit(idx, `T2_IDX_IRQ_MASK)) begin
        irq_mask <= wdata[2:0];
      end
    end
  end

  // Sticky event bits; read clears, a new event in that cycle survives
  wire [2:0] events = {capture, low_wrap, high_wrap};
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (rd_status ? 3'h0 : irq_status) | events;
    end
  end

  // Timer request follows the flags, like the core's level request
  wire timer_en = clock_control[`T2_BIT_TIMER_IRQ_EN];
  wire next_timer_irq = timer_en && (control[`T2_BIT_HIGH_FLAG] ||
    (control[`T2_BIT_LOW_IRQ_EN] && control[`T2_BIT_LOW_FLAG]));

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_irq <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_timer_irq <= next_timer_irq;
      o_irq <= |(irq_status & irq_mask);
    end
  end

  // Read mux
  reg [7:0] rdata;
  reg known;
  always @* begin
    rdata = 8'h00;
    known = 1'b1;
    case (idx)
      `T2_IDX_CONTROL: rdata = control;
      `T2_IDX_RELOAD_LOW: rdata = reload_low;
      `T2_IDX_RELOAD_HIGH: rdata = reload_high;
      `T2_IDX_COUNT_LOW: rdata = count_low;
      `T2_IDX_COUNT_HIGH: rdata = count_high;
      `T2_IDX_CLOCK_CONTROL: rdata = clock_control;
      `T2_IDX_IRQ_STATUS: rdata = {5'h00, irq_status};
      `T2_IDX_IRQ_MASK: rdata = {5'h00, irq_mask};
      default: known = 1'b0;
    endcase
  end

  // One wait cycle per access keeps read data registered
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h00000000;
      o_response <= 2'h0;
      done <= 1'b0;
    end else begin
      if (access) begin
        o_waitrequest <= 1'b0;
        done <= 1'b1;
        o_readdata <= i_read ? {24'h000000, rdata} : 32'h00000000;
        o_response <= known ? 2'h0 : 2'h3;
      end else begin
        o_waitrequest <= 1'b1;
        done <= 1'b0;
      end
    end
  end
endmodule // timer2_control_reload

// ---- verification/tb_timer2_control_reload.sv ----
// Purpose: Scenario bench for the reload timer
// Assumes: Registers reached at byte address 4 x index
// Notes: Counts run on a divider unless a scenario selects the system clock
`timescale 1ns/100ps
module tb_timer2_control_reload;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [9:0] addr = 10'h000;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg cmp = 1'b0;
  reg ext = 1'b0;
  wire [31:0] rdata;
  wire [1:0] resp;
  wire wt, tirq, irq;
  integer err_total = 0;
  integer samples_checked = 0;
  reg [7:0] d;
  reg [1:0] last;
  always #50 clk = ~clk;
  always @(posedge clk) ext <= ~ext;
  timer2_control_reload dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd),
    .i_write(wr), .i_writedata(wdata), .i_byteenable(4'hf), .i_comparator(cmp),
    .i_ext_clk(ext), .o_readdata(rdata), .o_waitrequest(wt), .o_response(resp),
    .o_timer_irq(tirq), .o_irq(irq));
  task end_sim;
    begin
      $display("Checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk8(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk_in(input [7:0] got, input [7:0] lo, input [7:0] hi);
    begin
      samples_checked = samples_checked + 1;
      if ((^got === 1'bx) || got < lo || got > hi) begin
        err_total = err_total + 1;
        $display("Error %0t: %h outside %h..%h", $time, got, lo, hi);
      end
    end
  endtask
  // Request held until waitrequest is sampled low
  task bus(input w, input [7:0] ix, input [7:0] v);
    integer n;
    begin
      @(posedge clk);
      addr <= {ix, 2'b00};
      wdata <= {24'h0, v};
      rd <= ~w;
      wr <= w;
      n = 0;
      @(posedge clk);
      while (wt !== 1'b0 && n < 20) begin
        n = n + 1;
        @(posedge clk);
      end
      d = rdata[7:0];
      last = resp;
      if (n == 20) begin
        err_total = err_total + 1;
        $display("Error %0t: bus answer timed out", $time);
      end
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task w8(input [7:0] ix, input [7:0] v);
    bus(1'b1, ix, v);
  endtask
  task r8(input [7:0] ix, input [7:0] exp);
    begin
      bus(1'b0, ix, 8'h00);
      chk8(d, exp);
    end
  endtask
  task t_reset;
    begin
      r8(8'hc8, 8'h00);
      r8(8'hca, 8'h00);
      r8(8'hcb, 8'h00);
      r8(8'hc2, 8'h00);
    end
  endtask
  task t_regs;
    begin
      w8(8'hca, 8'ha5);
      r8(8'hca, 8'ha5);
      w8(8'hcb, 8'h5a);
      r8(8'hcb, 8'h5a);
      w8(8'hc8, 8'h3a);
      r8(8'hc8, 8'h38);
      w8(8'hc8, 8'h00);
      r8(8'h10, 8'h00);
      chk8({6'h0, last}, 8'h03);
    end
  endtask
  task t_wrap;
    begin
      w8(8'hc0, 8'h03);
      w8(8'hca, 8'h34);
      w8(8'hcb, 8'h12);
      w8(8'hcc, 8'hf0);
      w8(8'hcd, 8'hff);
      w8(8'hc8, 8'h04);
      repeat (20) @(posedge clk);
      r8(8'hc8, 8'hc4);
      r8(8'hcd, 8'h12);
      w8(8'hc8, 8'hc0);
      chk8({7'h0, tirq}, 8'h00);
      w8(8'hc0, 8'h07);
      repeat (3) @(posedge clk);
      chk8({7'h0, tirq}, 8'h01);
      chk8({7'h0, irq}, 8'h00);
      w8(8'hc2, 8'h01);
      repeat (3) @(posedge clk);
      chk8({7'h0, irq}, 8'h01);
      r8(8'hc1, 8'h03);
      repeat (3) @(posedge clk);
      chk8({7'h0, irq}, 8'h00);
      w8(8'hc8, 8'h00);
      repeat (3) @(posedge clk);
      chk8({7'h0, tirq}, 8'h00);
    end
  endtask
  task t_split;
    begin
      w8(8'hc0, 8'h03);
      w8(8'hca, 8'hf0);
      w8(8'hcb, 8'h00);
      w8(8'hcc, 8'hf0);
      w8(8'hcd, 8'h10);
      w8(8'hc8, 8'h08);
      repeat (30) @(posedge clk);
      r8(8'hcd, 8'h10);
      r8(8'hc8, 8'h48);
      bus(1'b0, 8'hcc, 8'h00);
      chk_in(d, 8'hf0, 8'hff);
      w8(8'hc8, 8'h0c);
      w8(8'hcd, 8'hfe);
      repeat (4) @(posedge clk);
      bus(1'b0, 8'hc8, 8'h00);
      chk8(d & 8'h8f, 8'h8c);
      w8(8'hc0, 8'h07);
      w8(8'hc8, 8'h08);
      repeat (20) @(posedge clk);
      chk8({7'h0, tirq}, 8'h00);
      w8(8'hc8, 8'h28);
      repeat (20) @(posedge clk);
      chk8({7'h0, tirq}, 8'h01);
    end
  endtask
  task t_capture;
    begin
      w8(8'hc8, 8'h00);
      w8(8'hcc, 8'hcd);
      w8(8'hcd, 8'hab);
      w8(8'hc8, 8'h10);
      chk8({7'h0, tirq}, 8'h00);
      @(posedge clk);
      cmp <= 1'b1;
      repeat (8) @(posedge clk);
      r8(8'hca, 8'hcd);
      r8(8'hcb, 8'hab);
      r8(8'hc8, 8'h90);
      chk8({7'h0, tirq}, 8'h01);
      cmp <= 1'b0;
    end
  endtask
  // Divider phase is unknown, so divided counts are accepted anywhere from 8 to 0x0b
  task t_prescale;
    begin
      w8(8'hc0, 8'h00);
      w8(8'hc8, 8'h00);
      w8(8'hcc, 8'h00);
      w8(8'hc8, 8'h04);
      repeat (120) @(posedge clk);
      bus(1'b0, 8'hcc, 8'h00);
      chk_in(d, 8'h08, 8'h0b);
      w8(8'hc8, 8'h00);
      w8(8'hcc, 8'h00);
      w8(8'hc8, 8'h05);
      repeat (160) @(posedge clk);
      bus(1'b0, 8'hcc, 8'h00);
      chk_in(d, 8'h08, 8'h0b);
      w8(8'hc8, 8'h00);
      w8(8'hc0, 8'h02);
      w8(8'hcc, 8'h00);
      w8(8'hcd, 8'h00);
      w8(8'hc8, 8'h0d);
      repeat (160) @(posedge clk);
      bus(1'b0, 8'hcc, 8'h00);
      chk_in(d, 8'h08, 8'h0b);
      bus(1'b0, 8'hcd, 8'h00);
      chk_in(d, 8'h9c, 8'ha8);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_wrap;
    t_split;
    t_capture;
    t_prescale;
    end_sim;
  end
  initial begin
    repeat (6000) @(posedge clk);
    err_total = err_total + 1;
    $display("Error %0t: watchdog expired", $time);
    end_sim;
  end
endmodule // tb_timer2_control_reload

// ---- verification/timer2_chk.sv ----
// Purpose: Port checks for the reload timer
// Assumes: One clock; reset active low
// Notes: Counts are internal, so only bus and irq timing are watched
`timescale 1ns/100ps
module timer2_chk (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [9:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] o_readdata,
  input wire o_waitrequest,
  input wire [1:0] o_response,
  input wire o_timer_irq,
  input wire o_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire req = i_read | i_write;
  wire acc = req & ~o_waitrequest;
  wire [7:0] ix = i_address[9:2];
  wire mapped = (ix >= 8'hc0 && ix <= 8'hc2) || ix == 8'hc8 || (ix >= 8'hca && ix <= 8'hcd);
  chk_wait_one: assert property (req && o_waitrequest |=> !o_waitrequest)
    else $error("no answer one cycle after request");
  chk_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("answer longer than one cycle");
  chk_wait_idle: assert property (!req |=> o_waitrequest)
    else $error("answer without request");
  chk_ctl_bit1: assert property (acc && i_read && ix == 8'hc8 |-> !o_readdata[1])
    else $error("unused control bit reads one");
  chk_resp_bad: assert property (acc && !mapped |-> o_response == 2'b11)
    else $error("unmapped access not refused");
  chk_resp_ok: assert property (acc && mapped |-> o_response == 2'b00)
    else $error("mapped access refused");
  chk_unmapped_zero: assert property (acc && i_read && !mapped |-> o_readdata == 32'h00000000)
    else $error("unmapped read returned data");
  chk_flag_hold: assert property ($fell(o_timer_irq) |-> $past(i_write) || $past(i_write, 2))
    else $error("timer irq dropped without software write");
  chk_irq_clear: assert property ($fell(o_irq) |-> $past(req) || $past(req, 2))
    else $error("irq dropped without access");
  chk_rst_quiet: assert property ($rose(i_rst_n) |-> o_waitrequest && !o_irq && !o_timer_irq)
    else $error("outputs not at reset values");
  cov_read: cover property (acc && i_read);
  cov_tirq: cover property ($rose(o_timer_irq));
  cov_irq: cover property ($rose(o_irq));
endmodule // timer2_chk
bind timer2_control_reload timer2_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_address(i_address), .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
  .o_waitrequest(o_waitrequest), .o_response(o_response), .o_timer_irq(o_timer_irq),
  .o_irq(o_irq));
